// >>> pkg/nea_pkg.sv
// Purpose: Shared constants for the data NVM access block and its controller
// Assumes: One 100 MHz system clock, byte-wide special function register bus
// Notes:   Register offsets, bit positions, reset values and timing counts
package nea_pkg;
  // Storage geometry
  localparam int         NVM_DEPTH    = 128;
  localparam int         NVM_AW       = 7;
  // Direct special function register offsets, sector 0
  localparam logic [7:0] SFR_ADDR     = 8'h00;
  localparam logic [7:0] SFR_DATA     = 8'h01;
  localparam logic [7:0] SFR_PLO      = 8'h02;
  localparam logic [7:0] SFR_PHI      = 8'h03;
  localparam logic [7:0] SFR_IND      = 8'h04;
  localparam logic [7:0] SFR_INTC     = 8'h05;
  localparam logic [7:0] SFR_MFI      = 8'h06;
  // Pointer values that select the control register in sector 1, and the pointer reset value
  localparam logic [7:0] PTR_LO_CTRL  = 8'h40;
  localparam logic [7:0] PTR_HI_CTRL  = 8'h01;
  localparam logic [7:0] PTR_RST      = 8'h00;
  // Control register bits
  localparam int         CTL_FGO      = 0;
  localparam int         CTL_FARM     = 1;
  localparam int         CTL_PGO      = 2;
  localparam int         CTL_PARM     = 3;
  localparam logic [3:0] CTL_RST      = 4'h0;
  // Interrupt control bits
  localparam int         INTC_GIE     = 0;
  localparam int         INTC_MFE     = 1;
  localparam int         INTC_MFF     = 2;
  localparam int         MFI_NIE      = 0;
  localparam int         MFI_NDF      = 1;
  // Read cycle length and write timer shape, in system clocks and ticks
  localparam int         RD_CYCLES    = 4;
  localparam int         WT_DIV       = 7;
  localparam int         WT_TICKS     = 12;
  // Values the controller writes on the register bus
  localparam logic [7:0] CTRL_ARM_RD  = 8'h02;
  localparam logic [7:0] CTRL_GO_RD   = 8'h03;
  localparam logic [7:0] CTRL_ARM_WR  = 8'h08;
  localparam logic [7:0] CTRL_GO_WR   = 8'h0C;
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] INTC_GIE_OFF = 8'h02;
  localparam logic [7:0] INTC_GIE_ON  = 8'h03;
  localparam logic [7:0] MFI_CLR_DONE = 8'h01;
  // Controller APB register map and bits
  localparam logic [7:0] APB_CMD      = 8'h00;
  localparam logic [7:0] APB_ADDR     = 8'h04;
  localparam logic [7:0] APB_WDATA    = 8'h08;
  localparam logic [7:0] APB_STAT     = 8'h0C;
  localparam logic [7:0] APB_RDATA    = 8'h10;
  localparam int         CMD_RD       = 0;
  localparam int         CMD_WR       = 1;
  localparam int         ST_BUSY      = 0;
  localparam int         ST_DONE      = 1;
  localparam int         ST_IRQ       = 2;
endpackage

// >>> pkg/nea_sfr_if.sv
// Purpose: Register bus and interrupt lines between controller and NVM block
// Assumes: All signals synchronous to clk_sys of both ends
// Notes:   One strobe per instruction; read data valid the cycle after sfr_rd
`timescale 1ns/1ps
interface nea_sfr_if;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       irq_req;
  logic       irq_ack;

  modport dev (
    input  sfr_addr,
    input  sfr_wr,
    input  sfr_rd,
    input  sfr_wdata,
    input  irq_ack,
    output sfr_rdata,
    output irq_req
  );

  modport host (
    output sfr_addr,
    output sfr_wr,
    output sfr_rd,
    output sfr_wdata,
    output irq_ack,
    input  sfr_rdata,
    input  irq_req
  );
endinterface

// >>> hw/nea_wtimer.sv
// Purpose: Write cycle timer running on its own free tick, not the start edge
// Assumes: start is a one-cycle pulse given only while not busy
// Notes:   Length varies by up to one tick with the tick phase at start
`timescale 1ns/1ps
module nea_wtimer (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import nea_pkg::*;

  localparam logic [3:0] DIV_LAST  = 4'(WT_DIV - 1);
  localparam logic [4:0] TICK_LAST = 5'(WT_TICKS - 1);

  logic [3:0] div_ff;
  logic [4:0] tick_ff;
  logic       busy_ff;
  logic       tick;

  assign tick = (div_ff == DIV_LAST);
  assign busy = busy_ff;
  assign done = busy_ff && tick && (tick_ff == TICK_LAST);

  // Free-running tick source, unrelated to when a write starts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_ff <= 4'h0;
    end else if (tick) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  // Tick counter for one write cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      tick_ff <= 5'h00;
    end else if (start) begin
      busy_ff <= 1'b1;
      tick_ff <= 5'h00;
    end else if (done) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && tick) begin
      tick_ff <= tick_ff + 5'h01;
    end
  end
endmodule

// >>> hw/nea_dev.sv
// Purpose: Data NVM access logic: address, data, indirect control register
// Assumes: Controller keeps the arm/go ordering and the pointer setup
// Notes:   Write timing comes from nea_wtimer; reads take RD_CYCLES clocks
`timescale 1ns/1ps
// Behaviour
// (RQ1) Read starts on fetch_go; cleared when done
// (RQ2) fetch_go ignored unless fetch_arm already set
// (RQ3) Software never sets all bits together
// (RQ4) Read order: arm, address, then go
// (RQ5) Data register holds fetched byte until next op
// (RQ6) Write: address, data, arm, go back-to-back
// (RQ7) Global interrupt off around arm/go sequence; the controller does this for writes only, not for reads
// (RQ8) program_go ignored unless program_arm already set
// (RQ9) Write timed by independent internal timer
// (RQ10) program_go cleared when write finishes
// (RQ11) program_arm cleared at power-on
// (RQ12) Pointer high byte resets to sector 0
// (RQ13) Write end sets done and multi-function flags
// (RQ14) Software enables three interrupt enables
// (RQ15) Service clears only multi-function flag
// (RQ16) No sleep until a cycle finishes
// (RQ17) Control reached via pointer 01H/040H indirectly
// (RQ18) Optional read-back check after write
// (RQ19) Control bits 3..0 as listed, upper zero
// (RQ20) Address 7 bits, data 8, reset zero
// (RQ21) Cleared arm blocks further operations
// (RQ22) Read completes in fixed parameterised clocks
module nea_dev (
  input  wire logic clk_sys,
  input  wire logic rst,
  nea_sfr_if.dev    sfr,
  output logic      nvm_busy
);
  import nea_pkg::*;

  localparam logic [2:0] RD_LAST = 3'(RD_CYCLES - 1);

  logic [7:0]        mem [0:NVM_DEPTH-1];
  logic [NVM_AW-1:0] addr_ff;
  logic [7:0]        data_ff;
  logic [7:0]        ptr_lo_ff;
  logic [7:0]        ptr_hi_ff;
  logic [3:0]        ctrl_ff;
  logic [NVM_AW-1:0] op_addr_ff;
  logic [7:0]        op_data_ff;
  logic [2:0]        rd_cnt_ff;
  logic              gie_ff;
  logic              mfe_ff;
  logic              mff_ff;
  logic              nie_ff;
  logic              ndf_ff;
  logic [7:0]        rdata_ff;
  logic              ctrl_sel;
  logic              wr_ctrl;
  logic              idle;
  logic              start_read;
  logic              start_write;
  logic              read_done;
  logic              write_done;
  logic              wt_busy;

  // Control register is visible only through the pointer pair
  assign ctrl_sel = (ptr_hi_ff == PTR_HI_CTRL) && (ptr_lo_ff == PTR_LO_CTRL); // RQ17
  assign wr_ctrl  = sfr.sfr_wr && (sfr.sfr_addr == SFR_IND) && ctrl_sel;
  // Busy also while the write timer still runs, so no start can overlap it
  assign idle     = !ctrl_ff[CTL_FGO] && !ctrl_ff[CTL_PGO] && !wt_busy;
  // Go bits act only if the arm bit was already set
  assign start_read  = wr_ctrl && sfr.sfr_wdata[CTL_FGO] && ctrl_ff[CTL_FARM] && idle; // RQ2 RQ21
  assign start_write = wr_ctrl && sfr.sfr_wdata[CTL_PGO] && ctrl_ff[CTL_PARM] && idle; // RQ8 RQ21
  assign read_done   = ctrl_ff[CTL_FGO] && (rd_cnt_ff == RD_LAST); // RQ22
  assign nvm_busy    = !idle;
  assign sfr.sfr_rdata = rdata_ff;
  // Interrupt request to the core
  assign sfr.irq_req = gie_ff && mfe_ff && nie_ff && mff_ff;

  // Write cycle timer
  nea_wtimer nea_wtimer_inst (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (start_write),
    .busy    (wt_busy),
    .done    (write_done)  // RQ9
  );

  // Control bits: arm bits by software, go bits set on start, cleared by hardware
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTL_RST; // RQ11 RQ19
    end else begin
      if (wr_ctrl) begin
        ctrl_ff[CTL_FARM] <= sfr.sfr_wdata[CTL_FARM];
        ctrl_ff[CTL_PARM] <= sfr.sfr_wdata[CTL_PARM];
      end
      if (start_read) begin
        ctrl_ff[CTL_FGO] <= 1'b1; // RQ1
      end else if (read_done) begin
        ctrl_ff[CTL_FGO] <= 1'b0; // RQ1
      end
      if (start_write) begin
        ctrl_ff[CTL_PGO] <= 1'b1;
      end else if (write_done) begin
        ctrl_ff[CTL_PGO] <= 1'b0; // RQ10
      end
    end
  end

  // Read cycle counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_cnt_ff <= 3'h0;
    end else if (start_read) begin
      rd_cnt_ff <= 3'h0;
    end else if (ctrl_ff[CTL_FGO] && !read_done) begin
      rd_cnt_ff <= rd_cnt_ff + 3'h1;
    end
  end

  // Operation address and data latched at start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_addr_ff <= '0;
      op_data_ff <= 8'h00;
    end else if (start_read || start_write) begin
      op_addr_ff <= addr_ff;
      op_data_ff <= data_ff;
    end
  end

  // Storage array
  always_ff @(posedge clk_sys) begin
    if (write_done) begin
      mem[op_addr_ff] <= op_data_ff;
    end
  end

  // Address and pointer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_ff   <= '0; // RQ20
      ptr_lo_ff <= PTR_RST;
      ptr_hi_ff <= PTR_RST; // RQ12
    end else if (sfr.sfr_wr) begin
      if (sfr.sfr_addr == SFR_ADDR) begin
        addr_ff <= sfr.sfr_wdata[NVM_AW-1:0];
      end
      if (sfr.sfr_addr == SFR_PLO) begin
        ptr_lo_ff <= sfr.sfr_wdata;
      end
      if (sfr.sfr_addr == SFR_PHI) begin
        ptr_hi_ff <= sfr.sfr_wdata;
      end
    end
  end

  // Data register: fetched byte wins over a software write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_ff <= 8'h00; // RQ20
    end else if (read_done) begin
      data_ff <= mem[op_addr_ff]; // RQ5
    end else if (sfr.sfr_wr && sfr.sfr_addr == SFR_DATA) begin
      data_ff <= sfr.sfr_wdata;
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gie_ff <= 1'b0;
      mfe_ff <= 1'b0;
      nie_ff <= 1'b0;
    end else if (sfr.sfr_wr) begin
      if (sfr.sfr_addr == SFR_INTC) begin
        gie_ff <= sfr.sfr_wdata[INTC_GIE];
        mfe_ff <= sfr.sfr_wdata[INTC_MFE];
      end
      if (sfr.sfr_addr == SFR_MFI) begin
        nie_ff <= sfr.sfr_wdata[MFI_NIE];
      end
    end
  end

  // Sticky flags: write end sets both, set wins over any clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mff_ff <= 1'b0;
      ndf_ff <= 1'b0;
    end else begin
      if (write_done) begin
        mff_ff <= 1'b1; // RQ13
      end else if (sfr.irq_ack) begin
        mff_ff <= 1'b0; // RQ15
      end else if (sfr.sfr_wr && sfr.sfr_addr == SFR_INTC) begin
        mff_ff <= sfr.sfr_wdata[INTC_MFF];
      end
      if (write_done) begin
        ndf_ff <= 1'b1; // RQ13
      end else if (sfr.sfr_wr && sfr.sfr_addr == SFR_MFI) begin
        ndf_ff <= sfr.sfr_wdata[MFI_NDF]; // RQ15
      end
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (sfr.sfr_rd) begin
      case (sfr.sfr_addr)
        SFR_ADDR: rdata_ff <= {1'b0, addr_ff}; // RQ20
        SFR_DATA: rdata_ff <= data_ff;
        SFR_PLO:  rdata_ff <= ptr_lo_ff;
        SFR_PHI:  rdata_ff <= ptr_hi_ff;
        SFR_IND:  rdata_ff <= ctrl_sel ? {4'h0, ctrl_ff} : 8'h00; // RQ19
        SFR_INTC: rdata_ff <= {5'h00, mff_ff, mfe_ff, gie_ff};
        SFR_MFI:  rdata_ff <= {6'h00, ndf_ff, nie_ff};
        default:  rdata_ff <= 8'h00;
      endcase
    end
  end
endmodule

// >>> hw/nea_host.sv
// Purpose: Controller that runs read and write sequences on the NVM block
// Assumes: APB master issues commands; one bus operation per clock
// Notes:   Polls the go bits; services the interrupt by acknowledging it
`timescale 1ns/1ps
module nea_host (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  nea_sfr_if.host           sfr,
  input  wire logic [7:0]   paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              sleep_ok
);
  import nea_pkg::*;

  typedef enum {
    S_IDLE, R_PLO, R_PHI, R_ARM, R_ADR, R_GO, R_POLL, R_CHK, R_DIS, R_PCLR, R_GET, R_CAP,
    W_ADR, W_DAT, W_PLO, W_PHI, W_GOFF, W_ARM, W_GO, W_GON, W_POLL, W_CHK, W_DIS,
    W_PCLR, W_CLRF
  } nea_hstate_t;

  nea_hstate_t state_ff;
  nea_hstate_t nxt_state;
  logic [6:0]  addr_ff;
  logic [7:0]  wdata_ff;
  logic [7:0]  rdata_ff;
  logic        done_ff;
  logic        irq_ff;
  logic [31:0] prdata_ff;
  logic        apb_wr;
  logic        mapped;
  logic        cmd_rd;
  logic        cmd_wr;
  logic        op_wr;
  logic        op_rd;
  logic [7:0]  op_addr;
  logic [7:0]  op_data;

  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign mapped   = (paddr == APB_CMD) || (paddr == APB_ADDR) || (paddr == APB_WDATA)
                 || (paddr == APB_STAT) || (paddr == APB_RDATA);
  assign pslverr  = psel && penable && !mapped;
  assign apb_wr   = psel && penable && pwrite && mapped;
  // A command is refused while busy or when both kinds are asked at once
  assign cmd_rd   = apb_wr && paddr == APB_CMD && (state_ff == S_IDLE)
                 && pwdata[CMD_RD] && !pwdata[CMD_WR]; // RQ3 RQ18
  assign cmd_wr   = apb_wr && paddr == APB_CMD && (state_ff == S_IDLE)
                 && pwdata[CMD_WR] && !pwdata[CMD_RD]; // RQ3
  assign sleep_ok = (state_ff == S_IDLE); // RQ16
  assign sfr.sfr_wr    = op_wr;
  assign sfr.sfr_rd    = op_rd;
  assign sfr.sfr_addr  = op_addr;
  assign sfr.sfr_wdata = op_data;
  // Servicing the interrupt clears only the multi-function flag
  assign sfr.irq_ack   = sfr.irq_req; // RQ15

  // At most one bus operation per state (none in idle, check and capture states), then the next step
  always_comb begin
    nxt_state = state_ff;
    op_wr     = 1'b0;
    op_rd     = 1'b0;
    op_addr   = SFR_IND;
    op_data   = CTRL_OFF;
    case (state_ff)
      S_IDLE: begin
        if (cmd_rd) nxt_state = R_PLO;
        if (cmd_wr) nxt_state = W_ADR;
      end
      R_PLO: begin
        op_wr     = 1'b1;
        op_addr   = SFR_PLO;
        op_data   = PTR_LO_CTRL; // RQ17
        nxt_state = R_PHI;
      end
      R_PHI: begin
        op_wr     = 1'b1;
        op_addr   = SFR_PHI;
        op_data   = PTR_HI_CTRL; // RQ17
        nxt_state = R_ARM;
      end
      R_ARM: begin
        op_wr     = 1'b1;
        op_data   = CTRL_ARM_RD; // RQ4
        nxt_state = R_ADR;
      end
      R_ADR: begin
        op_wr     = 1'b1;
        op_addr   = SFR_ADDR;
        op_data   = {1'b0, addr_ff};
        nxt_state = R_GO;
      end
      R_GO: begin
        op_wr     = 1'b1;
        op_data   = CTRL_GO_RD; // RQ4
        nxt_state = R_POLL;
      end
      R_POLL: begin
        op_rd     = 1'b1;
        nxt_state = R_CHK;
      end
      R_CHK:  nxt_state = sfr.sfr_rdata[CTL_FGO] ? R_POLL : R_DIS; // RQ16
      R_DIS: begin
        op_wr     = 1'b1;
        nxt_state = R_PCLR;
      end
      R_PCLR: begin
        op_wr     = 1'b1;
        op_addr   = SFR_PHI;
        op_data   = PTR_RST;
        nxt_state = R_GET;
      end
      R_GET: begin
        op_rd     = 1'b1;
        op_addr   = SFR_DATA;
        nxt_state = R_CAP;
      end
      R_CAP:  nxt_state = S_IDLE;
      W_ADR: begin
        op_wr     = 1'b1;
        op_addr   = SFR_ADDR;
        op_data   = {1'b0, addr_ff}; // RQ6
        nxt_state = W_DAT;
      end
      W_DAT: begin
        op_wr     = 1'b1;
        op_addr   = SFR_DATA;
        op_data   = wdata_ff;
        nxt_state = W_PLO;
      end
      W_PLO: begin
        op_wr     = 1'b1;
        op_addr   = SFR_PLO;
        op_data   = PTR_LO_CTRL; // RQ17
        nxt_state = W_PHI;
      end
      W_PHI: begin
        op_wr     = 1'b1;
        op_addr   = SFR_PHI;
        op_data   = PTR_HI_CTRL;
        nxt_state = W_GOFF;
      end
      W_GOFF: begin
        op_wr     = 1'b1;
        op_addr   = SFR_INTC;
        op_data   = INTC_GIE_OFF; // RQ7
        nxt_state = W_ARM;
      end
      W_ARM: begin
        op_wr     = 1'b1;
        op_data   = CTRL_ARM_WR; // RQ6
        nxt_state = W_GO;
      end
      W_GO: begin
        op_wr     = 1'b1;
        op_data   = CTRL_GO_WR; // RQ6
        nxt_state = W_GON;
      end
      W_GON: begin
        op_wr     = 1'b1;
        op_addr   = SFR_INTC;
        op_data   = INTC_GIE_ON; // RQ7 RQ14
        nxt_state = W_POLL;
      end
      W_POLL: begin
        op_rd     = 1'b1;
        nxt_state = W_CHK;
      end
      W_CHK:  nxt_state = sfr.sfr_rdata[CTL_PGO] ? W_POLL : W_DIS; // RQ16
      W_DIS: begin
        op_wr     = 1'b1;
        nxt_state = W_PCLR;
      end
      W_PCLR: begin
        op_wr     = 1'b1;
        op_addr   = SFR_PHI;
        op_data   = PTR_RST;
        nxt_state = W_CLRF;
      end
      W_CLRF: begin
        op_wr     = 1'b1;
        op_addr   = SFR_MFI;
        op_data   = MFI_CLR_DONE; // RQ14 RQ15
        nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command operands from APB
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_ff  <= 7'h00;
      wdata_ff <= 8'h00;
    end else if (apb_wr && state_ff == S_IDLE) begin
      if (paddr == APB_ADDR) addr_ff <= pwdata[6:0];
      if (paddr == APB_WDATA) wdata_ff <= pwdata[7:0];
    end
  end

  // Fetched byte and sticky status; set wins over write-one-to-clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      done_ff  <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      if (state_ff == R_CAP) rdata_ff <= sfr.sfr_rdata;
      if (state_ff == R_CAP || state_ff == W_CLRF) begin
        done_ff <= 1'b1;
      end else if (apb_wr && paddr == APB_STAT && pwdata[ST_DONE]) begin
        done_ff <= 1'b0;
      end
      if (sfr.irq_req) begin
        irq_ff <= 1'b1;
      end else if (apb_wr && paddr == APB_STAT && pwdata[ST_IRQ]) begin
        irq_ff <= 1'b0;
      end
    end
  end

  // APB read data captured in the setup cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        APB_ADDR:  prdata_ff <= {25'h0, addr_ff};
        APB_WDATA: prdata_ff <= {24'h0, wdata_ff};
        APB_STAT:  prdata_ff <= {29'h0, irq_ff, done_ff, state_ff != S_IDLE};
        APB_RDATA: prdata_ff <= {24'h0, rdata_ff};
        default:   prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// >>> tb/nea_chk.sv
// Purpose: Assertions on the register bus between controller and NVM block
// Assumes: One clk_sys domain, rst asynchronous active high
// Notes:   Shadows pointer, control and enable writes to know cycle starts
`timescale 1ns/1ps
module nea_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       irq_req,
  input wire logic       irq_ack,
  input wire logic       nvm_busy
);
  import nea_pkg::*;
  logic [7:0] plo_ff;
  logic [7:0] phi_ff;
  logic [3:0] ctl_ff;
  logic       nie_ff;
  logic       ie_ff;
  logic       ctl_hit;
  logic       ctl_wr;
  // Control register selected through the pointer pair
  assign ctl_hit = sfr_addr == SFR_IND && plo_ff == PTR_LO_CTRL && phi_ff == PTR_HI_CTRL;
  assign ctl_wr  = ctl_hit && sfr_wr;
  // Shadow of what the controller last wrote
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      plo_ff <= 8'h00;
      phi_ff <= 8'h00;
      ctl_ff <= 4'h0;
      nie_ff <= 1'b0;
      ie_ff  <= 1'b0;
    end else if (sfr_wr) begin
      if (sfr_addr == SFR_PLO) plo_ff <= sfr_wdata;
      if (sfr_addr == SFR_PHI) phi_ff <= sfr_wdata;
      if (ctl_hit) ctl_ff <= sfr_wdata[3:0];
      if (sfr_addr == SFR_MFI) nie_ff <= sfr_wdata[MFI_NIE];
      if (sfr_addr == SFR_INTC) ie_ff <= sfr_wdata[INTC_GIE] && sfr_wdata[INTC_MFE];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_rd_go;
    ctl_wr && sfr_wdata == CTRL_GO_RD && ctl_ff[CTL_FARM] && !nvm_busy;
  endsequence
  sequence s_wr_go;
    ctl_wr && sfr_wdata == CTRL_GO_WR && ctl_ff[CTL_PARM] && !nvm_busy;
  endsequence
  chk_read_len: assert property (s_rd_go |=> nvm_busy [*4] ##1 !nvm_busy)
    else $error("read cycle length wrong");
  chk_write_len: assert property (s_wr_go |=> nvm_busy [*8] ##[71:77] $fell(nvm_busy))
    else $error("write cycle length wrong");
  chk_busy_cause: assert property ($rose(nvm_busy) |-> $past(ctl_wr))
    else $error("cycle started without control write");
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  chk_ctl_layout: assert property (sfr_rd && ctl_hit |=> sfr_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  chk_go_visible: assert property (sfr_rd && ctl_hit |=>
      (sfr_rdata[CTL_FGO] || sfr_rdata[CTL_PGO]) == $past(nvm_busy))
    else $error("go bits disagree with busy");
  chk_done_irq: assert property ($fell(nvm_busy) && ctl_ff == CTRL_GO_WR[3:0] && nie_ff
      && ie_ff |-> irq_req)
    else $error("no request at write end");
  chk_ack_clears: assert property (irq_ack |=> !irq_req)
    else $error("service did not clear request");
endmodule

// >>> tb/data_eeprom_access_control_bench.sv
// Purpose: Self-checking bench for controller and NVM block joined back to back
// Assumes: clk_sys 100 MHz, rst held 4 cycles
// Notes:   Drives the controller over APB; expectations from stored values
`timescale 1ns/1ps
module data_eeprom_access_control_bench;
  import nea_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_ok;
  logic        nvm_busy;
  logic [31:0] rd_q;
  logic        err_q;
  int          n_mismatch;
  int          samples_checked;
  nea_sfr_if sfr_bus ();
  nea_dev nea_dev_inst (.clk_sys(clk_sys), .rst(rst), .sfr(sfr_bus.dev), .nvm_busy(nvm_busy));
  nea_host nea_host_inst (.clk_sys(clk_sys), .rst(rst), .sfr(sfr_bus.host), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_ok(sleep_ok));
  nea_chk nea_chk_inst (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_bus.sfr_addr),
    .sfr_wr(sfr_bus.sfr_wr), .sfr_rd(sfr_bus.sfr_rd), .sfr_wdata(sfr_bus.sfr_wdata),
    .sfr_rdata(sfr_bus.sfr_rdata), .irq_req(sfr_bus.irq_req), .irq_ack(sfr_bus.irq_ack),
    .nvm_busy(nvm_busy));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; result left in rd_q and err_q
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Wait for the slave however long it takes; only the watchdog ends this
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Poll status until the sequencer is idle
  task automatic wait_idle();
    int k;
    k = 0;
    apb(1'b0, APB_STAT, 32'h0);
    while (rd_q[ST_BUSY] !== 1'b0 && k < 300) begin
      apb(1'b0, APB_STAT, 32'h0);
      k++;
    end
    cmp({31'h0, rd_q[ST_BUSY]}, 32'h0);
  endtask
  task automatic t_reset();
    apb(1'b0, APB_STAT, 32'h0);
    cmp(rd_q, 32'h0);
    apb(1'b0, APB_RDATA, 32'h0);
    cmp(rd_q, 32'h0);
    cmp({31'h0, sleep_ok}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    cmp({31'h0, err_q}, 32'h1);
    apb(1'b1, APB_CMD, 32'h3);
    apb(1'b0, APB_STAT, 32'h0);
    cmp(rd_q, 32'h0);
    apb(1'b1, APB_ADDR, 32'h85);
    apb(1'b0, APB_ADDR, 32'h0);
    cmp(rd_q, 32'h05);
  endtask
  task automatic t_write(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, APB_ADDR, {24'h0, a});
    apb(1'b1, APB_WDATA, {24'h0, d});
    apb(1'b1, APB_CMD, 32'h2);
    apb(1'b0, APB_STAT, 32'h0);
    cmp({31'h0, rd_q[ST_BUSY]}, 32'h1);
    cmp({31'h0, sleep_ok}, 32'h0);
    apb(1'b1, APB_WDATA, 32'hFF);
    wait_idle();
    apb(1'b0, APB_STAT, 32'h0);
    cmp(rd_q & 32'h6, 32'h6);
    apb(1'b1, APB_STAT, 32'h6);
    apb(1'b0, APB_STAT, 32'h0);
    cmp(rd_q, 32'h0);
  endtask
  task automatic t_read(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, APB_ADDR, {24'h0, a});
    apb(1'b1, APB_CMD, 32'h1);
    wait_idle();
    apb(1'b0, APB_RDATA, 32'h0);
    cmp(rd_q, {24'h0, d});
    apb(1'b1, APB_STAT, 32'h6);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end
  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_write(8'h7F, 8'hA5);
    t_read(8'h7F, 8'hA5);
    t_write(8'h00, 8'h5A);
    t_read(8'h00, 8'h5A);
    t_read(8'h7F, 8'hA5);
    close_out();
  end
endmodule
